// ### core/adc_ctl_consts.svh
`ifndef ADC_CTL_CONSTS_SVH
`define ADC_CTL_CONSTS_SVH

`define OFS_CTRL_TWO      12'h000
`define OFS_OWN_CTRL      12'h004
`define OFS_ISR_BASE      12'h008
`define OFS_TRIG_SENSE    12'h00C
`define OFS_WARMUP        12'h010
`define OFS_SCAN_SEL_LOW  12'h014
`define OFS_SCAN_SEL_HIGH 12'h018
`define OFS_IRQ_STATUS    12'h01C
`define OFS_IRQ_MASK      12'h020
`define OFS_CONV_READY    12'h024
`define OFS_FILTER0       12'h040

`define BIT_REFS_READY    31
`define BIT_REF_FAULT     30
`define BIT_SCAN_DONE     29
`define POS_DIV_CAP       26
`define BIT_FRAC_FMT      0
`define BIT_SCAN_LVL      1
`define BIT_FILT_EN       31
`define BIT_FILT_READY    24
`define POS_FILT_SEL      16
`define POS_WARMUP_CNT    24
`define BIT_SHARED_EN     7
`define POS_VEC_SHIFT     8

`define IRQ_SCAN_DONE     0
`define IRQ_REF_FAULT     1
`define IRQ_REFS_READY    2
`define IRQ_FILT0         3

`define FILTER_INPUTS     5'h0C
`define DIV_CAP_UNIT_FF   2500
`endif

// ### core/adc_ctl_pkg.sv
package adc_ctl_pkg;
  typedef struct packed {
    logic        enable;
    logic [4:0]  input_sel;
    logic        ready;
    logic [15:0] result;
  } filter_reg_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  filter_id;
    logic [11:0] sample;
  } filter_out_t;

  typedef struct packed {
    logic       done;
    logic [5:0] input_id;
  } conv_event_t;
endpackage

// ### core/adc_status_filter_vector_logic.sv
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "adc_ctl_consts.svh"
module adc_status_filter_vector_logic
  import adc_ctl_pkg::*;
#(
  parameter int NUM_INPUTS  = 44,
  parameter int NUM_FILTERS = 6,
  parameter int NUM_TRIG    = 12
)(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   module_on,
  input  wire logic                   bandgap_ready,
  input  wire logic                   vref_ready,
  input  wire logic                   ref_fault_event,
  input  wire conv_event_t            conv_event,
  input  wire filter_out_t            filter_out,
  input  wire logic [NUM_INPUTS-1:0]  input_ready,
  input  wire logic [NUM_TRIG-1:0]    trig_pin,
  input  wire logic                   scan_trig_pin,
  output logic [NUM_TRIG-1:0]         trig_fire,
  output logic                        scan_fire,
  output logic [6:0]                  cap_unit_en,
  output logic [4:0]                  filter_input_sel [NUM_FILTERS],
  output logic [5:0]                  analog_power_en,
  output logic [5:0]                  conv_usable,
  output logic                        irq
);

  localparam int NIRQ = `IRQ_FILT0 + NUM_FILTERS;

  logic              refs_ready_r;
  logic              ref_fault_r;
  logic              scan_done_r;
  logic [2:0]        divider_cap_sel_r;
  logic              fractional_format_r;
  logic              scan_trigger_level_r;
  logic [15:0]       isr_base_r;
  logic [2:0]        vector_shift_r;
  logic [NUM_TRIG-1:0] trigger_sense_r;
  logic [5:0]        analog_enable_r;
  logic [3:0]        warmup_count_r;
  logic [NUM_INPUTS-1:0] scan_select_r;
  logic [NUM_INPUTS-1:0] scanned_r;
  logic [NIRQ-1:0]   irq_status_r;
  logic [NIRQ-1:0]   irq_mask_r;
  filter_reg_t       filt_r [NUM_FILTERS];
  logic [15:0]       warm_cnt_r [6];
  logic [NUM_TRIG-1:0] trig_s1_r;
  logic [NUM_TRIG-1:0] trig_s2_r;
  logic [NUM_TRIG-1:0] trig_s3_r;
  logic [2:0]        scan_sync_r;
  logic              refs_ok_d_r;

  logic              wr_en;
  logic              rd_en;
  logic              addr_hit;
  logic [NUM_INPUTS-1:0] scanned_nxt;
  logic              scan_complete;
  logic              refs_ok;
  logic [NUM_FILTERS-1:0] filt_set;
  logic [NUM_FILTERS-1:0] filt_clr;
  logic [15:0]       vector_addr;
  logic [NIRQ-1:0]   irq_events;

  function automatic logic [5:0] lowest_ready(input logic [NUM_INPUTS-1:0] rdy);
    logic [5:0] idx;
    idx = 6'h00;
    for (int i = NUM_INPUTS - 1; i >= 0; i--)
    begin
      if (rdy[i])
        idx = 6'(i);
    end
    return idx;
  endfunction

  function automatic logic is_filter_addr(input logic [11:0] a, input int f);
    return a == (`OFS_FILTER0 + 12'(f * 4));
  endfunction

  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;
  assign pready = 1'b1;

  // Reference status
  assign refs_ok = bandgap_ready & vref_ready;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refs_ready_r <= 1'b0;
    else
      refs_ready_r <= module_on & refs_ok;
  end

  // Raw reference readiness is used: the flag itself is forced low while off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ref_fault_r <= 1'b0;
    else if (module_on & ref_fault_event)
      ref_fault_r <= 1'b1;
    else if (~module_on & refs_ok)
      ref_fault_r <= 1'b0;
  end

  // Scan completion tracking
  assign scanned_nxt   = scanned_r |
                         (conv_event.done ? (NUM_INPUTS'(1) << conv_event.input_id) : '0);
  assign scan_complete = (|scan_select_r) && ((scanned_nxt & scan_select_r) == scan_select_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scanned_r <= '0;
    else if (scan_complete)
      scanned_r <= '0;
    else
      scanned_r <= scanned_nxt;
  end

  // Set wins over the read clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scan_done_r <= 1'b0;
    else if (scan_complete)
      scan_done_r <= 1'b1;
    else if (rd_en && paddr == `OFS_CTRL_TWO)
      scan_done_r <= 1'b0;
  end

  // Software configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      divider_cap_sel_r    <= 3'h0;
      fractional_format_r  <= 1'b0;
      scan_trigger_level_r <= 1'b0;
      vector_shift_r       <= 3'h0;
      isr_base_r           <= 16'h0000;
      trigger_sense_r      <= '0;
      analog_enable_r      <= 6'h00;
      warmup_count_r       <= 4'h0;
      scan_select_r        <= '0;
      irq_mask_r           <= '0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `OFS_CTRL_TWO:
          divider_cap_sel_r <= pwdata[`POS_DIV_CAP +: 3];
        `OFS_OWN_CTRL:
        begin
          fractional_format_r  <= pwdata[`BIT_FRAC_FMT];
          scan_trigger_level_r <= pwdata[`BIT_SCAN_LVL];
          vector_shift_r       <= pwdata[`POS_VEC_SHIFT +: 3];
        end
        `OFS_ISR_BASE:
          isr_base_r <= pwdata[15:0];
        `OFS_TRIG_SENSE:
          trigger_sense_r <= pwdata[NUM_TRIG-1:0];
        `OFS_WARMUP:
        begin
          analog_enable_r <= {pwdata[`BIT_SHARED_EN], pwdata[4:0]};
          warmup_count_r  <= pwdata[`POS_WARMUP_CNT +: 4];
        end
        `OFS_SCAN_SEL_LOW:
          scan_select_r[31:0] <= pwdata;
        `OFS_SCAN_SEL_HIGH:
          scan_select_r[NUM_INPUTS-1:32] <= pwdata[NUM_INPUTS-33:0];
        `OFS_IRQ_MASK:
          irq_mask_r <= pwdata[NIRQ-1:0];
        default:
          irq_mask_r <= irq_mask_r;
      endcase
    end
  end

  // Thermometer of unit capacitors, one per 2.5 pF step
  always_comb
  begin
    for (int u = 0; u < 7; u++)
      cap_unit_en[u] = (3'(u) < divider_cap_sel_r);
  end

  // Digital filters
  generate
    for (genvar f = 0; f < NUM_FILTERS; f++)
    begin : g_filt
      logic sel_ok;
      logic wr_hit;
      assign sel_ok = filt_r[f].input_sel < `FILTER_INPUTS;
      assign wr_hit = wr_en && is_filter_addr(paddr, f);
      assign filt_set[f] = filter_out.valid && filter_out.filter_id == 3'(f) &&
                           filt_r[f].enable && sel_ok;
      assign filt_clr[f] = (rd_en && is_filter_addr(paddr, f)) ||
                           (wr_hit && !pwdata[`BIT_FILT_EN]);
      assign filter_input_sel[f] = filt_r[f].input_sel;

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          filt_r[f] <= '0;
        else
        begin
          if (wr_hit)
          begin
            filt_r[f].enable    <= pwdata[`BIT_FILT_EN];
            filt_r[f].input_sel <= pwdata[`POS_FILT_SEL +: 5];
          end
          // Format is frozen into the stored word at capture time
          if (filt_set[f])
            filt_r[f].result <= fractional_format_r ? {filter_out.sample, 4'h0}
                                                    : {4'h0, filter_out.sample};
          if (filt_set[f])
            filt_r[f].ready <= 1'b1;
          else if (filt_clr[f])
            filt_r[f].ready <= 1'b0;
        end
      end
    end
  endgenerate

  // Jump-table vector; lowest ID wins, plain base when none is ready
  assign vector_addr = (|input_ready)
                     ? 16'(isr_base_r + (16'(lowest_ready(input_ready)) << vector_shift_r))
                     : isr_base_r;

  // Trigger pins: two-stage sync, third stage only for edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_s1_r   <= '0;
      trig_s2_r   <= '0;
      trig_s3_r   <= '0;
      scan_sync_r <= 3'h0;
    end
    else
    begin
      trig_s1_r   <= trig_pin;
      trig_s2_r   <= trig_s1_r;
      trig_s3_r   <= trig_s2_r;
      scan_sync_r <= {scan_sync_r[1:0], scan_trig_pin};
    end
  end

  assign trig_fire = trig_s2_r & (trigger_sense_r | ~trig_s3_r);
  assign scan_fire = scan_sync_r[1] & (scan_trigger_level_r | ~scan_sync_r[2]);

  // Warm-up: converter usable after 2^count clocks of enable
  generate
    for (genvar c = 0; c < 6; c++)
    begin : g_warm
      logic [15:0] target;
      assign target = 16'h0001 << warmup_count_r;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          warm_cnt_r[c] <= 16'h0000;
        else if (!analog_enable_r[c])
          warm_cnt_r[c] <= 16'h0000;
        else if (warm_cnt_r[c] < target)
          warm_cnt_r[c] <= warm_cnt_r[c] + 16'h0001;
      end
      assign conv_usable[c] = analog_enable_r[c] && warm_cnt_r[c] >= target;
    end
  endgenerate

  assign analog_power_en = analog_enable_r;

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refs_ok_d_r <= 1'b0;
    else
      refs_ok_d_r <= refs_ready_r;
  end

  assign irq_events = {filt_set, refs_ready_r & ~refs_ok_d_r,
                       module_on & ref_fault_event, scan_complete};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_r <= '0;
    else if (wr_en && paddr == `OFS_IRQ_STATUS)
      irq_status_r <= (irq_status_r & ~pwdata[NIRQ-1:0]) | irq_events;
    else
      irq_status_r <= irq_status_r | irq_events;
  end

  assign irq = |(irq_status_r & irq_mask_r);

  // Read mux and decode
  always_comb
  begin
    prdata   = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (paddr)
      `OFS_CTRL_TWO:
        prdata = {refs_ready_r, ref_fault_r, scan_done_r, divider_cap_sel_r, 26'h0};
      `OFS_OWN_CTRL:
        prdata = {21'h0, vector_shift_r, 6'h00, scan_trigger_level_r, fractional_format_r};
      `OFS_ISR_BASE:
        prdata = {16'h0000, vector_addr};
      `OFS_TRIG_SENSE:
        prdata = 32'(trigger_sense_r);
      `OFS_WARMUP:
        prdata = {4'h0, warmup_count_r, 16'h0000, analog_enable_r[5], 2'h0,
                  analog_enable_r[4:0]};
      `OFS_SCAN_SEL_LOW:
        prdata = scan_select_r[31:0];
      `OFS_SCAN_SEL_HIGH:
        prdata = 32'(scan_select_r[NUM_INPUTS-1:32]);
      `OFS_IRQ_STATUS:
        prdata = 32'(irq_status_r);
      `OFS_IRQ_MASK:
        prdata = 32'(irq_mask_r);
      `OFS_CONV_READY:
        prdata = {26'h0, conv_usable};
      default:
      begin
        addr_hit = 1'b0;
        for (int f = 0; f < NUM_FILTERS; f++)
        begin
          if (is_filter_addr(paddr, f))
          begin
            addr_hit = 1'b1;
            prdata   = {filt_r[f].enable, 6'h00, filt_r[f].ready, 3'h0,
                        filt_r[f].input_sel, filt_r[f].result};
          end
        end
      end
    endcase
  end

  assign pslverr = psel & penable & ~addr_hit;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  refs_ready_off_a: assert property (!module_on |=> !refs_ready_r)
    else $error("refs ready while module off");
  refs_ready_on_a: assert property (module_on && refs_ok |=> refs_ready_r)
    else $error("refs ready missing");
  ref_fault_set_a: assert property (module_on && ref_fault_event |=> ref_fault_r)
    else $error("ref fault not set");
  ref_fault_clr_a: assert property (!module_on && refs_ok |=> !ref_fault_r)
    else $error("ref fault not cleared");
  scan_done_set_a: assert property (scan_complete |=> scan_done_r)
    else $error("scan done lost");
  scan_done_clr_a: assert property
    (rd_en && paddr == `OFS_CTRL_TWO && !scan_complete |=> !scan_done_r)
    else $error("scan done not cleared on read");
  cap_units_a: assert property ($countones(cap_unit_en) == divider_cap_sel_r)
    else $error("cap unit count wrong");
  filt_ready_a: assert property (filt_set[0] |=> filt_r[0].ready)
    else $error("filter ready not set");
  filt_clear_a: assert property (filt_clr[0] && !filt_set[0] |=> !filt_r[0].ready)
    else $error("filter ready not cleared");
  filt_source_a: assert property
    (filt_r[0].input_sel >= `FILTER_INPUTS |-> !filt_set[0])
    else $error("reserved input fed a filter");
  filt_format_a: assert property (filt_set[0] && fractional_format_r
    |=> filt_r[0].result == {$past(filter_out.sample), 4'h0})
    else $error("fractional format not applied");
  vector_idle_a: assert property (input_ready == '0 |-> vector_addr == isr_base_r)
    else $error("vector not base when idle");
  vector_low_a: assert property (input_ready[0] |->
    vector_addr == isr_base_r)
    else $error("input zero vector wrong");
  edge_once_a: assert property (!trigger_sense_r[0] && trig_fire[0] |=> !trig_fire[0])
    else $error("edge trigger refired");
  level_fire_a: assert property (trigger_sense_r[0] && trig_s2_r[0] |-> trig_fire[0])
    else $error("level trigger missed");
  scan_edge_a: assert property (!scan_trigger_level_r && scan_fire |=> !scan_fire)
    else $error("scan edge refired");
  warm_gate_a: assert property ($rose(analog_enable_r[5]) && warmup_count_r != 4'h0
    |-> !conv_usable[5][*2])
    else $error("converter usable before warm-up");

  scan_done_c: cover property (scan_complete ##1 rd_en && paddr == `OFS_CTRL_TWO);
  filt_cycle_c: cover property (filt_set[0] ##[1:20] filt_clr[0]);
  vector_c: cover property (input_ready[5] && !input_ready[0] && vector_shift_r == 3'h2);
  irq_c: cover property ($rose(irq));

endmodule

// ### tb/adc_far_model.sv
`timescale 1ns/1ps
module adc_far_model
  import adc_ctl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        filt_go,
  input  wire logic [2:0]  filt_id,
  input  wire logic [11:0] filt_smp,
  input  wire logic        conv_go,
  input  wire logic [5:0]  conv_id,
  output filter_out_t      filter_out,
  output conv_event_t      conv_event
);
  // One-cycle pulses; idle fields toggle so stale data never looks fresh
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      filter_out <= '0;
      conv_event <= '0;
    end
    else
    begin
      filter_out <= filt_go ? {1'b1, filt_id, filt_smp} : {1'b0, ~filter_out[14:0]};
      conv_event <= conv_go ? {1'b1, conv_id} : {1'b0, ~conv_event[5:0]};
    end
endmodule

// ### tb/adc_status_filter_vector_logic_tb.sv
`timescale 1ns/1ps
`include "adc_ctl_consts.svh"
module adc_status_filter_vector_logic_tb import adc_ctl_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, trig_pin, trig_fire, filt_smp, fa;
  logic [31:0] pwdata, prdata, rd, seed, s, base;
  logic        module_on, bandgap_ready, vref_ready, ref_fault_event;
  logic        scan_trig_pin, scan_fire, irq, filt_go, conv_go;
  conv_event_t conv_event;
  filter_out_t filter_out;
  logic [43:0] input_ready;
  logic [6:0]  cap_unit_en;
  logic [4:0]  fsel [6];
  logic [5:0]  analog_power_en, conv_usable, conv_id;
  logic [2:0]  filt_id, sh;
  logic [63:0] r;
  logic [15:0] r0;
  int          error_cnt, n_compared, cyc, cnt_t, cnt_s, n, sel, idx;

  adc_status_filter_vector_logic dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .module_on(module_on), .bandgap_ready(bandgap_ready),
    .vref_ready(vref_ready), .ref_fault_event(ref_fault_event), .conv_event(conv_event),
    .filter_out(filter_out), .input_ready(input_ready), .trig_pin(trig_pin),
    .scan_trig_pin(scan_trig_pin), .trig_fire(trig_fire), .scan_fire(scan_fire),
    .cap_unit_en(cap_unit_en), .filter_input_sel(fsel), .analog_power_en(analog_power_en),
    .conv_usable(conv_usable), .irq(irq));
  adc_far_model far_u (.pclk(pclk), .presetn(presetn), .filt_go(filt_go), .filt_id(filt_id),
    .filt_smp(filt_smp), .conv_go(conv_go), .conv_id(conv_id), .filter_out(filter_out),
    .conv_event(conv_event));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Lowest ready input wins, so scan from the top down
  function automatic logic [31:0] vec_exp(input logic [15:0] b, input logic [43:0] v,
                                          input logic [2:0] k);
    logic [15:0] x;
    x = b;
    for (int i = 43; i >= 0; i--)
      if (v[i])
        x = b + (16'(i) << k);
    return {16'h0000, x};
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a stuck wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, ex, rd);
  endtask

  task automatic pulse(input logic f, input logic [5:0] id, input logic [11:0] v);
    filt_go <= f;
    conv_go <= !f;
    filt_id <= id[2:0];
    conv_id <= id;
    filt_smp <= v;
    @(posedge pclk);
    filt_go <= 1'b0;
    conv_go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run needs a few hundred cycles; anything far past that is a hang
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial
  begin
    seed = 32'h0000_08B5;
    {error_cnt, n_compared, cyc} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {module_on, bandgap_ready, vref_ready, ref_fault_event, input_ready} = '0;
    {trig_pin, scan_trig_pin, filt_go, filt_id, filt_smp, conv_go, conv_id} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 36; a += 4)
      rdc("reset value", 12'(a), 32'h0000_0000);
    module_on <= 1'b1;
    bandgap_ready <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc("refs one", `OFS_CTRL_TWO, 32'h0000_0000);
    vref_ready <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc("refs both", `OFS_CTRL_TWO, 32'h8000_0000);
    ref_fault_event <= 1'b1;
    @(posedge pclk);
    ref_fault_event <= 1'b0;
    repeat (2) @(posedge pclk);
    rdc("fault on", `OFS_CTRL_TWO, 32'hC000_0000);
    module_on <= 1'b0;
    repeat (3) @(posedge pclk);
    rdc("fault off", `OFS_CTRL_TWO, 32'h0000_0000);
    for (int k = 7; k >= 0; k--)
    begin
      apb(1'b1, `OFS_CTRL_TWO, 32'(k) << 26);
      rdc("divider", `OFS_CTRL_TWO, 32'(k) << 26);
      chk("cap units", (32'h1 << k) - 32'h1, 32'(cap_unit_en));
    end
    apb(1'b1, `OFS_SCAN_SEL_LOW, 32'h0000_0005);
    pulse(1'b0, 6'h00, 12'h000);
    pulse(1'b0, 6'h01, 12'h000);
    rdc("scan half", `OFS_CTRL_TWO, 32'h0000_0000);
    pulse(1'b0, 6'h02, 12'h000);
    rdc("scan done", `OFS_CTRL_TWO, 32'h2000_0000);
    rdc("scan clear", `OFS_CTRL_TWO, 32'h0000_0000);
    rdc("irq status", `OFS_IRQ_STATUS, 32'h0000_0007);
    chk("irq masked", 32'h0, irq);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
    chk("irq raised", 32'h1, irq);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h0000_0007);
    chk("irq cleared", 32'h0, irq);
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, `OFS_TRIG_SENSE, 32'(m));
      apb(1'b1, `OFS_OWN_CTRL, 32'(m) << 1);
      {cnt_t, cnt_s} = '0;
      trig_pin[0] <= 1'b1;
      scan_trig_pin <= 1'b1;
      for (int c = 0; c < 20; c++)
      begin
        @(posedge pclk);
        if (c == 9)
          {trig_pin[0], scan_trig_pin} <= 2'b00;
        cnt_t += int'(trig_fire[0]);
        cnt_s += int'(scan_fire);
      end
      chk("trig fires", m ? 10 : 1, cnt_t);
      chk("scan fires", m ? 10 : 1, cnt_s);
    end
    apb(1'b1, `OFS_OWN_CTRL, 32'h0000_0000);
    for (int f = 0; f < 6; f++)
    begin
      s = rnd();
      sel = rnd() % 12;
      fa = 12'(`OFS_FILTER0 + 4 * f);
      apb(1'b1, fa, 32'h8000_0000 | (sel << 16));
      chk("sel out", sel, fsel[f]);
      pulse(1'b1, 6'(f), s[11:0]);
      rdc("filter word", fa, 32'h8100_0000 | (sel << 16) | s[11:0]);
      rdc("ready read", fa, 32'h8000_0000 | (sel << 16) | s[11:0]);
      if (f == 0)
        r0 = {4'h0, s[11:0]};
    end
    rdc("filter irq", `OFS_IRQ_STATUS, 32'h0000_01F8);
    sel = 12 + rnd() % 20;
    apb(1'b1, `OFS_FILTER0, 32'h8000_0000 | (sel << 16));
    pulse(1'b1, 6'h00, 12'hABC);
    rdc("reserved sel", `OFS_FILTER0, 32'h8000_0000 | (sel << 16) | r0);
    apb(1'b1, `OFS_FILTER0, 32'h800B_0000);
    pulse(1'b1, 6'h00, 12'h5A3);
    // Format only changes with every filter off
    for (int f = 0; f < 6; f++)
      apb(1'b1, 12'(`OFS_FILTER0 + 4 * f), 32'h0000_0000);
    apb(1'b1, `OFS_OWN_CTRL, 32'h0000_0001);
    rdc("frozen fmt", `OFS_FILTER0, 32'h0000_05A3);
    apb(1'b1, `OFS_FILTER0, 32'h800B_0000);
    pulse(1'b1, 6'h00, 12'h5A3);
    rdc("fraction fmt", `OFS_FILTER0, 32'h810B_5A30);
    apb(1'b1, `OFS_FILTER0, 32'h0000_0000);
    base = rnd();
    apb(1'b1, `OFS_ISR_BASE, {16'h0000, base[15:0]});
    for (int k = 0; k < 8; k++)
    begin
      sh = 3'(rnd());
      idx = k == 0 ? 43 : rnd() % 44;
      r = {rnd(), rnd()};
      r = ((r >> idx) << idx) | (64'h1 << idx);
      apb(1'b1, `OFS_OWN_CTRL, 32'(sh) << 8);
      input_ready <= r[43:0];
      @(posedge pclk);
      rdc("vector", `OFS_ISR_BASE, vec_exp(base[15:0], r[43:0], sh));
    end
    input_ready <= '0;
    @(posedge pclk);
    rdc("vector none", `OFS_ISR_BASE, {16'h0000, base[15:0]});
    apb(1'b1, `OFS_WARMUP, 32'h0200_0081);
    chk("power", 32'h21, analog_power_en);
    chk("early use", 32'h0, conv_usable);
    n = 0;
    while (conv_usable !== 6'h21 && n < 64)
    begin
      @(posedge pclk);
      n++;
    end
    chk("warm-up", 32'h4, 32'(n));
    rdc("usable reg", `OFS_CONV_READY, 32'h0000_0021);
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    chk("unmapped wr", 32'h1, err);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped rd", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    report_and_stop();
  end
endmodule
